// ### core/irq_ctl_pkg.sv
// Constants for the socket interrupt and general control register bank
`default_nettype none
package irq_ctl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTL_A       = 12'h003;
  localparam logic [11:0] IDX_CTL_B       = 12'h043;
  localparam logic [11:0] IDX_CTL_A_ALIAS = 12'h803;
  localparam logic [11:0] IDX_ROUTE_CTL   = 12'h900;
  localparam logic [11:0] IDX_IRQ_STAT    = 12'h901;
  localparam logic [11:0] IDX_IRQ_MASK    = 12'h902;
  localparam int          IDX_LSB         = 2;
  localparam int          IDX_MSB         = 13;
  // Control register fields
  localparam int          RING_BIT        = 7;
  localparam int          RESET_BIT       = 6;
  localparam int          KIND_BIT        = 5;
  localparam int          ROUTE_BIT       = 4;
  localparam int          SEL_MSB         = 3;
  localparam logic [7:0]  CTL_RESET_VAL   = 8'h00;
  // Bits kept over a bus reset while power events are enabled
  localparam logic [7:0]  CTL_PME_KEEP    = 8'h60;
  // Own registers
  localparam logic        ROUTE_RESET_VAL = 1'h1;
  localparam logic [1:0]  STAT_RESET_VAL  = 2'h0;
  localparam logic [1:0]  MASK_RESET_VAL  = 2'h0;
  // Interrupt select codes
  localparam logic [3:0]  SEL_NONE        = 4'h0;
  localparam logic [3:0]  SEL_IRQ1        = 4'h1;
  localparam logic [3:0]  SEL_SMI         = 4'h2;
  localparam logic [3:0]  SEL_IRQ3        = 4'h3;
  localparam logic [3:0]  SEL_IRQ4        = 4'h4;
  localparam logic [3:0]  SEL_IRQ9        = 4'h9;
  localparam logic [3:0]  SEL_IRQ10       = 4'ha;
  localparam logic [3:0]  SEL_IRQ13       = 4'hd;
  // Line number = code + offset for codes 0xa..0xd
  localparam logic [3:0]  HI_IRQ_BASE     = 4'h0;
  // AHB transfer type bit for NONSEQ/SEQ
  localparam int          HTRANS_ACT_BIT  = 1;
endpackage : irq_ctl_pkg
`default_nettype wire

// ### core/irq_ctl_bank.sv
// Two-socket interrupt and general control register bank with AHB-Lite slave
// What this block does
// - one 8-bit control register per socket, A at 03h/803h, B at 43h
// - bit 7 enables ring indicate on the battery/ring pin, reset off
// - bit 6 zero holds card RESET asserted, one releases it
// - bit 5 records card kind, zero memory, one I/O
// - with routing control zero, bit 4 sends status changes to PCI
// - with routing control one, bit 4 is ignored
// - select code 0000 means no IRQ and also routes status changes to PCI
// - bits 3-0 route the functional interrupt to IRQ1, SYSTEM_MANAGEMENT_IRQ, IRQ3-13
// - bits 6,5 survive bus reset while power events are enabled
// - with ring indicate on, status bit 0 shows the ring input
`default_nettype none
module irq_ctl_bank
  import irq_ctl_pkg::*;
(
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  input  wire  logic        global_reset_pin,
  input  wire  logic        pci_bus_reset_pin,
  input  wire  logic        pme_enable,
  input  wire  logic [1:0]  battery_detect_ring_pin,
  input  wire  logic [1:0]  card_status_change,
  input  wire  logic [1:0]  card_func_irq,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output var   logic [31:0] hrdata,
  output var   logic        hreadyout,
  output var   logic        hresp,
  output var   logic [1:0]  ring_indicate_enable,
  output var   logic [1:0]  card_reset,
  output var   logic [1:0]  card_kind_select,
  output var   logic [1:0]  status_change_to_pci_route,
  output var   logic [1:0]  status_bit0,
  output var   logic [15:0] legacy_irq,
  output var   logic        system_management_irq,
  output var   logic        irq
);

  // Storage
  logic [7:0]  ctl_ff [2];
  logic        route_ctl_ff;
  logic [1:0]  stat_ff;
  logic [1:0]  mask_ff;
  logic        wr_pend_ff;
  logic [11:0] wr_idx_ff;
  logic [31:0] hrdata_ff;
  logic [15:0] legacy_irq_ff;
  logic        smi_ff;
  logic        irq_ff;
  logic [1:0]  reset_out_ff;
  logic [1:0]  route_out_ff;
  logic [1:0]  stat0_ff;

  // Decode helpers
  logic [11:0] addr_idx;
  logic        addr_ok;
  logic        take;
  logic        hard_rst;
  logic        soft_rst;
  logic [15:0] nxt_legacy;
  logic        nxt_smi;

  assign addr_idx  = haddr[IDX_MSB:IDX_LSB];
  assign addr_ok   = (haddr[31:IDX_MSB+1] == 18'h0) && (haddr[1:0] == 2'h0);
  assign take      = hsel && hready && htrans[HTRANS_ACT_BIT];
  // Global pin acts like system reset on the control and routing registers only; bus reset is weaker
  assign hard_rst  = sys_rst || global_reset_pin;
  assign soft_rst  = pci_bus_reset_pin;

  // Address phase capture for writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 12'h000;
    end else begin
      wr_pend_ff <= take && hwrite && addr_ok;
      wr_idx_ff  <= addr_idx;
    end
  end

  // Read data is captured in the address phase, so it shows the old
  // contents if the previous data phase wrote the same register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata_ff <= 32'h0;
    end else if (take && !hwrite && addr_ok) begin
      if (addr_idx == IDX_CTL_A || addr_idx == IDX_CTL_A_ALIAS) begin
        hrdata_ff <= {24'h0, ctl_ff[0]};
      end else if (addr_idx == IDX_CTL_B) begin
        hrdata_ff <= {24'h0, ctl_ff[1]};
      end else if (addr_idx == IDX_ROUTE_CTL) begin
        hrdata_ff <= {31'h0, route_ctl_ff};
      end else if (addr_idx == IDX_IRQ_STAT) begin
        hrdata_ff <= {30'h0, stat_ff};
      end else if (addr_idx == IDX_IRQ_MASK) begin
        hrdata_ff <= {30'h0, mask_ff};
      end else begin
        hrdata_ff <= 32'h0;
      end
    end else begin
      hrdata_ff <= 32'h0;
    end
  end

  // Never waits, always OKAY
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  assign hrdata = hrdata_ff;

  // Per-socket control registers with split reset domains
  always_ff @(posedge clk) begin
    for (int s = 0; s < 2; s++) begin
      if (hard_rst || (soft_rst && !pme_enable)) begin
        ctl_ff[s] <= CTL_RESET_VAL;
      end else if (soft_rst) begin
        ctl_ff[s] <= ctl_ff[s] & CTL_PME_KEEP;
      end else if (wr_pend_ff && ((s == 0 &&
                   (wr_idx_ff == IDX_CTL_A || wr_idx_ff == IDX_CTL_A_ALIAS)) ||
                   (s == 1 && wr_idx_ff == IDX_CTL_B))) begin
        ctl_ff[s] <= hwdata[7:0];
      end
    end
  end

  // Routing control, defaults to one so bit 4 is ignored
  always_ff @(posedge clk) begin
    if (hard_rst || soft_rst) begin
      route_ctl_ff <= ROUTE_RESET_VAL;
    end else if (wr_pend_ff && wr_idx_ff == IDX_ROUTE_CTL) begin
      route_ctl_ff <= hwdata[0];
    end
  end

  // Sticky status-change flags; a new event beats a write-one clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_ff <= STAT_RESET_VAL;
    end else if (wr_pend_ff && wr_idx_ff == IDX_IRQ_STAT) begin
      stat_ff <= (stat_ff & ~hwdata[1:0]) | card_status_change;
    end else begin
      stat_ff <= stat_ff | card_status_change;
    end
  end

  // Interrupt mask, one per socket
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_ff <= MASK_RESET_VAL;
    end else if (wr_pend_ff && wr_idx_ff == IDX_IRQ_MASK) begin
      mask_ff <= hwdata[1:0];
    end
  end

  // Interrupt level output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end
  assign irq = irq_ff;

  // Functional interrupt routing; unassigned codes drive no line
  always_comb begin
    nxt_legacy = 16'h0;
    nxt_smi    = 1'b0;
    for (int s = 0; s < 2; s++) begin
      if (card_func_irq[s]) begin
        if (ctl_ff[s][SEL_MSB:0] == SEL_IRQ1) begin
          nxt_legacy[1] = 1'b1;
        end else if (ctl_ff[s][SEL_MSB:0] == SEL_SMI) begin
          nxt_smi = 1'b1;
        end else if (ctl_ff[s][SEL_MSB:0] >= SEL_IRQ3 &&
                     ctl_ff[s][SEL_MSB:0] <= SEL_IRQ13 &&
                     (ctl_ff[s][SEL_MSB:0] <= SEL_IRQ9 ||
                      ctl_ff[s][SEL_MSB:0] >= SEL_IRQ10)) begin
          nxt_legacy[ctl_ff[s][SEL_MSB:0] + HI_IRQ_BASE] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      legacy_irq_ff <= 16'h0;
      smi_ff        <= 1'b0;
    end else begin
      legacy_irq_ff <= nxt_legacy;
      smi_ff        <= nxt_smi;
    end
  end
  assign legacy_irq            = legacy_irq_ff;
  assign system_management_irq = smi_ff;

  // Card-facing controls, registered so every output leaves a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_out_ff <= 2'h3;
      route_out_ff <= 2'h3;
      stat0_ff     <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        reset_out_ff[s] <= !ctl_ff[s][RESET_BIT];
        if (route_ctl_ff) begin
          route_out_ff[s] <= (ctl_ff[s][SEL_MSB:0] == SEL_NONE);
        end else begin
          route_out_ff[s] <= ctl_ff[s][ROUTE_BIT] ||
                             (ctl_ff[s][SEL_MSB:0] == SEL_NONE);
        end
        // Ring input replaces battery status when enabled
        stat0_ff[s] <= ctl_ff[s][RING_BIT] ? !battery_detect_ring_pin[s]
                                           : battery_detect_ring_pin[s];
      end
    end
  end
  assign card_reset                 = reset_out_ff;
  assign status_change_to_pci_route = route_out_ff;
  assign status_bit0                = stat0_ff;

  // Plain register bits go straight out
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      ring_indicate_enable[s] = ctl_ff[s][RING_BIT];
      card_kind_select[s]     = ctl_ff[s][KIND_BIT];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_alias_write_hits: assert property (
    wr_pend_ff && wr_idx_ff == IDX_CTL_A_ALIAS && !hard_rst && !soft_rst
    |=> ctl_ff[0] == $past(hwdata[7:0]) && $stable(ctl_ff[1]))
    else $error("alias write did not reach socket A");

  a_ring_follows: assert property (
    wr_pend_ff && wr_idx_ff == IDX_CTL_B && !hard_rst && !soft_rst
    |=> ring_indicate_enable[1] == $past(hwdata[RING_BIT]))
    else $error("ring enable does not follow bit 7");

  a_card_reset_pin: assert property (
    ##1 card_reset[0] == !$past(ctl_ff[0][RESET_BIT]))
    else $error("card reset not inverse of bit 6");

  a_kind_bit: assert property (
    wr_pend_ff && wr_idx_ff == IDX_CTL_A && !hard_rst && !soft_rst
    |=> card_kind_select[0] == $past(hwdata[KIND_BIT]))
    else $error("card kind does not follow bit 5");

  a_route_bit4: assert property (
    !route_ctl_ff && ctl_ff[0][ROUTE_BIT] |=> status_change_to_pci_route[0])
    else $error("bit 4 did not route to PCI");

  a_route_ignore: assert property (
    route_ctl_ff && ctl_ff[0][SEL_MSB:0] != SEL_NONE
    |=> !status_change_to_pci_route[0])
    else $error("bit 4 not ignored under routing control");

  a_zero_code_pci: assert property (
    ctl_ff[1][SEL_MSB:0] == SEL_NONE |=> status_change_to_pci_route[1])
    else $error("code 0000 did not route to PCI");

  a_smi_route: assert property (
    card_func_irq == 2'h1 && ctl_ff[0][SEL_MSB:0] == SEL_SMI
    |=> system_management_irq && legacy_irq == 16'h0)
    else $error("SYSTEM_MANAGEMENT_IRQ code misrouted");

  a_pme_keep: assert property (
    soft_rst && pme_enable && !global_reset_pin
    |=> ctl_ff[0] == ($past(ctl_ff[0]) & CTL_PME_KEEP))
    else $error("bus reset under power events lost bits 6,5");

  a_ring_status: assert property (
    ctl_ff[0][RING_BIT] |=> status_bit0[0] == !$past(battery_detect_ring_pin[0]))
    else $error("status bit 0 does not show ring input");

  a_unused_code: assert property (
    card_func_irq == 2'h1 && ctl_ff[0][SEL_MSB:0] > SEL_IRQ13
    |=> legacy_irq == 16'h0 && !system_management_irq)
    else $error("unassigned code drove a line");

  a_irq_level: assert property (
    |(stat_ff & mask_ff) |=> irq)
    else $error("unmasked status did not raise irq");

endmodule : irq_ctl_bank
`default_nettype wire

// ### verif/card_model.sv
// Behavioural 16-bit card model for both sockets
`default_nettype none
module card_model (
  input  wire logic       clk,
  input  wire logic [1:0] card_reset,
  input  wire logic [1:0] ring_req,
  input  wire logic [1:0] irq_req,
  input  wire logic [1:0] ev_req,
  output var  logic [1:0] battery_detect_ring_pin,
  output var  logic [1:0] card_func_irq,
  output var  logic [1:0] card_status_change
);
  timeunit 1ns;
  timeprecision 100ps;
  // Ring line is active low; a card held in reset raises no functional interrupt
  always_ff @(posedge clk) begin
    battery_detect_ring_pin <= ~ring_req;
    card_func_irq           <= irq_req & ~card_reset;
    card_status_change      <= ev_req;
  end
endmodule : card_model
`default_nettype wire

// ### verif/test_socket_irq_general_control.sv
// Self-checking bench for the socket control register bank
`default_nettype none
module test_socket_irq_general_control
  import irq_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] A_CTL = {18'h0, IDX_CTL_A, 2'h0};
  localparam logic [31:0] A_ALS = {18'h0, IDX_CTL_A_ALIAS, 2'h0};
  localparam logic [31:0] B_CTL = {18'h0, IDX_CTL_B, 2'h0};
  localparam logic [31:0] R_CTL = {18'h0, IDX_ROUTE_CTL, 2'h0};
  localparam logic [31:0] I_STA = {18'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [31:0] I_MSK = {18'h0, IDX_IRQ_MASK, 2'h0};
  localparam logic [31:0] UNMAP = 32'h40;
  logic        clk, sys_rst, global_reset_pin, pci_bus_reset_pin, pme_enable;
  logic        hsel, hwrite, hreadyout, hresp, system_management_irq, irq, rd_dp;
  logic [1:0]  htrans, ring_req, irq_req, ev_req, card_reset, battery_detect_ring_pin;
  logic [1:0]  card_status_change, card_func_irq, ring_indicate_enable, card_kind_select;
  logic [1:0]  status_change_to_pci_route, status_bit0;
  logic [2:0]  hsize;
  logic [15:0] legacy_irq;
  logic [31:0] haddr, hwdata, hrdata, exp_q[$];
  int          error_cnt, tests_run;

  irq_ctl_bank uut (.clk, .sys_rst, .global_reset_pin, .pci_bus_reset_pin, .pme_enable,
    .battery_detect_ring_pin, .card_status_change, .card_func_irq, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ring_indicate_enable, .card_reset, .card_kind_select, .status_change_to_pci_route,
    .status_bit0, .legacy_irq, .system_management_irq, .irq);
  card_model card (.clk, .card_reset, .ring_req, .irq_req, .ev_req,
    .battery_detect_ring_pin, .card_func_irq, .card_status_change);

  // Free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Bounded wait for ready; a hung slave ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) begin
        error_cnt++;
        finish_test;
      end
      @(posedge clk);
    end
  endtask : wait_rdy

  // One single word transfer; reads leave their expectation in the queue
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    if (!w) exp_q.push_back(d);
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp  <= !w;
    wait_rdy;
    rd_dp  <= 1'b0;
  endtask : bus

  // Pulse bus reset (p=1) or global reset (p=0)
  task automatic pulse_rst(input logic p, input logic pme);
    pme_enable <= pme;
    if (p) pci_bus_reset_pin <= 1'b1;
    else global_reset_pin <= 1'b1;
    cyc(2);
    pci_bus_reset_pin <= 1'b0;
    global_reset_pin  <= 1'b0;
    cyc(1);
  endtask : pulse_rst

  // Read data checked against the oldest note at the end of its data phase
  always @(posedge clk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, 32'h0);
    end
  end

  // Main sequence
  initial begin
    logic [7:0] va, vb, c;
    logic [7:0] rt[4];
    int ln;
    rt = '{8'h00, 8'h01, 8'h10, 8'h11};
    {sys_rst, global_reset_pin, pci_bus_reset_pin, pme_enable} = 4'h8;
    {hsel, hwrite, rd_dp, htrans, ring_req, irq_req, ev_req} = '0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    void'($urandom(21));
    cyc(8);
    sys_rst <= 1'b0;
    cyc(1);
    bus(0, A_CTL, 32'h0);
    bus(0, B_CTL, 32'h0);
    bus(0, R_CTL, 32'h1);
    bus(0, UNMAP, 32'h0);
    chk(card_reset, 2'h3);
    chk({ring_indicate_enable, card_kind_select, status_change_to_pci_route, irq}, 7'h06);
    // Random values through the alias and socket B
    va = 8'($urandom);
    vb = 8'($urandom);
    bus(1, A_ALS, {24'h0, va});
    bus(1, B_CTL, {24'h0, vb});
    bus(0, A_CTL, {24'h0, va});
    bus(0, B_CTL, {24'h0, vb});
    chk(ring_indicate_enable, {vb[7], va[7]});
    chk(card_reset, 2'(~{vb[6], va[6]}));
    chk(card_kind_select, {vb[5], va[5]});
    chk(status_change_to_pci_route, {vb[3:0] == 4'h0, va[3:0] == 4'h0});
    // Every select code, card out of reset and requesting
    irq_req <= 2'h1;
    for (int i = 0; i < 16; i++) begin
      c = 8'h60 | 8'(i);
      bus(1, A_CTL, {24'h0, c});
      cyc(4);
      ln = (c[3:0] >= SEL_IRQ10) ? int'(c[3:0] + HI_IRQ_BASE) : i;
      chk(legacy_irq, (c[3:0] inside {SEL_IRQ1, SEL_IRQ3, [SEL_IRQ4:SEL_IRQ13]})
        ? 16'h1 << ln : 16'h0);
      chk(system_management_irq, c[3:0] == SEL_SMI);
      chk(status_change_to_pci_route[0], i == 0);
    end
    // Routing bit cleared: bit 4 counts, ORed with code zero
    bus(1, R_CTL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      c = rt[k];
      bus(1, A_CTL, {24'h0, c});
      cyc(3);
      chk(status_change_to_pci_route[0], c[4] | (c[3:0] == 4'h0));
    end
    bus(1, R_CTL, 32'h1);
    cyc(3);
    chk(status_change_to_pci_route[0], 1'b0);
    // Ring input is active low and shows only while enabled
    bus(1, A_CTL, 32'hc0);
    ring_req <= 2'h1;
    cyc(4);
    chk(status_bit0[0], 1'b1);
    ring_req <= 2'h0;
    cyc(4);
    chk(status_bit0[0], 1'b0);
    bus(1, A_CTL, 32'h40);
    cyc(3);
    chk(status_bit0[0], 1'b1);
    // Bus reset keeps card reset and kind only while power events are on
    bus(1, A_CTL, 32'hff);
    pulse_rst(1'b1, 1'b1);
    bus(0, A_CTL, 32'h60);
    pulse_rst(1'b1, 1'b0);
    bus(0, A_CTL, 32'h0);
    bus(1, A_CTL, 32'hff);
    pulse_rst(1'b0, 1'b1);
    bus(0, A_CTL, 32'h0);
    // Sticky events, mask and write-one-to-clear
    bus(1, I_MSK, 32'h1);
    ev_req <= 2'h3;
    cyc(1);
    ev_req <= 2'h0;
    cyc(3);
    chk(irq, 1'b1);
    bus(0, I_STA, 32'h3);
    bus(1, I_STA, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    bus(0, I_STA, 32'h2);
    bus(1, I_MSK, 32'h3);
    cyc(2);
    chk(irq, 1'b1);
    bus(1, I_STA, 32'h2);
    cyc(2);
    chk(irq, 1'b0);
    finish_test;
  end
endmodule : test_socket_irq_general_control
`default_nettype wire
